// [rtl/lims_pkg.sv]
package lims_pkg;

   // ----------------------------------------------------------------------
   // Mode codes and layout
   // ----------------------------------------------------------------------

   // Indicator display modes, in the order of their 3-bit codes.
   typedef enum logic [2:0] {
      LIMS_MODE_LINK10OR1000,
      LIMS_MODE_LINK100OR1000,
      LIMS_MODE_LINKUP,
      LIMS_MODE_ACTIVITY,
      LIMS_MODE_LINKIDLE,
      LIMS_MODE_LINK10,
      LIMS_MODE_LINK100,
      LIMS_MODE_LINK1000
   } lims_mode_t;

   // Resolved link speed from the PHY.
   typedef enum logic [1:0] {
      LIMS_SPEED_10,
      LIMS_SPEED_100,
      LIMS_SPEED_1000,
      LIMS_SPEED_RSVD
   } lims_speed_t;

   // Link status as seen by the PHY.
   typedef struct packed {
      logic        linkUp;
      lims_speed_t speed;
      logic        txActive;
      logic        rxActive;
   } lims_link_t;

   // Per-output setting.
   typedef struct packed {
      lims_mode_t mode;
      logic       invert;
      logic       blink;
   } lims_out_cfg_t;

   localparam int           LIMS_NUM_OUT      = 3;
   localparam int           LIMS_CTL_WIDTH    = 16;
   localparam int           LIMS_MODE_LSB0    = 0;
   localparam int           LIMS_MODE_LSB1    = 5;
   localparam int           LIMS_MODE_LSB2    = 10;
   localparam int           LIMS_INVERT_OFS   = 3;
   localparam int           LIMS_BLINK_OFS    = 4;
   localparam int           LIMS_RATE_BIT     = 15;
   localparam logic [15:0]  LIMS_CTL_RESET    = 16'h18F4;
   localparam logic [2:0]   LIMS_LED_IDLE     = 3'h7; // All pins dark.

   // ----------------------------------------------------------------------
   // Blink timing
   // ----------------------------------------------------------------------

   localparam int  LIMS_CLK_HZ        = 25_000_000;
   localparam int  LIMS_SLOW_HALF_MS  = 200;
   localparam int  LIMS_FAST_HALF_MS  = 83;
   localparam int  LIMS_SLOW_CYCLES   = LIMS_CLK_HZ / 1000 * LIMS_SLOW_HALF_MS;
   localparam int  LIMS_FAST_CYCLES   = LIMS_CLK_HZ / 1000 * LIMS_FAST_HALF_MS;
   localparam int  LIMS_CNT_W         = 23;

endpackage

// [rtl/lims_blink_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// Half-period blink timer; the phase flips each time the selected
// half-period elapses. A rate change restarts the count.
module lims_blink_timer #(
   parameter int SLOW_CYCLES = lims_pkg::LIMS_SLOW_CYCLES,
   parameter int FAST_CYCLES = lims_pkg::LIMS_FAST_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic fastRate,
   output var  logic blinkPhase
);

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------

   localparam int W = lims_pkg::LIMS_CNT_W;

   logic [W-1:0] count_r;
   logic         rate_r;
   logic [W-1:0] limit;
   logic         wrap;
   logic         rateChange;

   assign limit      = fastRate ? W'(FAST_CYCLES - 1)
                                : W'(SLOW_CYCLES - 1); // [R09]
   assign wrap       = (count_r >= limit);
   assign rateChange = (rate_r != fastRate);

   // Counting restarts on a rate change so a half-period never overruns.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_r    <= '0;
         rate_r     <= 1'b0;
         blinkPhase <= 1'b1;
      end else begin
         rate_r <= fastRate;
         if (rateChange) begin
            count_r <= '0;
         end else if (wrap) begin
            count_r    <= '0;
            blinkPhase <= ~blinkPhase; // [R09]
         end else begin
            count_r <= count_r + W'(1);
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/led_indication_mode_selector.sv]
// How it works
// (R01) Mode 000: lit on 10 or 1000 link.
// (R02) Mode 001: lit on 100 or 1000 link.
// (R03) Mode 010: lit on any link.
// (R04) Mode 011: lit on link with traffic.
// (R05) Mode 100: lit on idle link only.
// (R06) Mode 101: lit on 10 link.
// (R07) Mode 110: lit on 100 link.
// (R08) Mode 111: lit on 1000 link.
// (R09) Shared rate: 200 ms or 83 ms halves.
// (R10) Per-output blink enable, steady when clear.
// (R11) Per-output invert; default active-low.
// (R12) Mode fields at 2:0, 7:5, 12:10.
// (R13) Independent outputs: condition, blink, then polarity.
// (R14) Blinking output stays inactive when condition false.
`timescale 1ns/1ps
`default_nettype none

module led_indication_mode_selector (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic                 linkUp,
   input  wire logic [1:0]           linkSpeed,
   input  wire logic                 txActive,
   input  wire logic                 rxActive,
   input  wire logic                 ctlLoad,
   input  wire logic [15:0]          indicatorControlIn,
   output var  logic [15:0]          indicatorControl,
   output var  logic [2:0]           ledOut
);

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------

   // PHY status arrives from outside this domain, so two stages each.
   lims_pkg::lims_link_t meta_r;
   lims_pkg::lims_link_t link_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_r <= '0;
         link_r <= '0;
      end else begin
         meta_r <= {linkUp, lims_pkg::lims_speed_t'(linkSpeed),
                    txActive, rxActive};
         link_r <= meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Control word
   // ----------------------------------------------------------------------

   // Reset gives the documented defaults; ctlLoad replaces the word.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         indicatorControl <= lims_pkg::LIMS_CTL_RESET; // [R12]
      end else if (ctlLoad) begin
         indicatorControl <= indicatorControlIn;
      end
   end

   // ----------------------------------------------------------------------
   // Link conditions
   // ----------------------------------------------------------------------

   logic isUp;
   logic is10;
   logic is100;
   logic is1000;
   logic busy;

   assign isUp   = link_r.linkUp;
   assign is10   = isUp && (link_r.speed == lims_pkg::LIMS_SPEED_10);
   assign is100  = isUp && (link_r.speed == lims_pkg::LIMS_SPEED_100);
   assign is1000 = isUp && (link_r.speed == lims_pkg::LIMS_SPEED_1000);
   assign busy   = link_r.txActive || link_r.rxActive;

   // ----------------------------------------------------------------------
   // Blink timer
   // ----------------------------------------------------------------------

   logic blinkPhase;

   lims_blink_timer u_timer (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .fastRate   (indicatorControl[lims_pkg::LIMS_RATE_BIT]), // [R09]
      .blinkPhase (blinkPhase)
   );

   // ----------------------------------------------------------------------
   // Per-output selection
   // ----------------------------------------------------------------------

   localparam int LSB [lims_pkg::LIMS_NUM_OUT] = '{
      lims_pkg::LIMS_MODE_LSB0, lims_pkg::LIMS_MODE_LSB1,
      lims_pkg::LIMS_MODE_LSB2};

   logic [2:0] ledNxt;

   for (genvar i = 0; i < lims_pkg::LIMS_NUM_OUT; i++) begin : g_out
      lims_pkg::lims_out_cfg_t cfg;
      logic                    cond;
      logic                    gated;

      assign cfg.mode   = lims_pkg::lims_mode_t'(
                          indicatorControl[LSB[i] +: 3]); // [R12]
      assign cfg.invert = indicatorControl[LSB[i] +
                          lims_pkg::LIMS_INVERT_OFS];
      assign cfg.blink  = indicatorControl[LSB[i] +
                          lims_pkg::LIMS_BLINK_OFS];

      // Each output decodes its own mode with no shared state.
      always_comb begin
         unique case (cfg.mode) // [R13]
            lims_pkg::LIMS_MODE_LINK10OR1000:  cond = is10 || is1000; // [R01]
            lims_pkg::LIMS_MODE_LINK100OR1000: cond = is100 || is1000; // [R02]
            lims_pkg::LIMS_MODE_LINKUP:        cond = isUp; // [R03]
            lims_pkg::LIMS_MODE_ACTIVITY:      cond = isUp && busy; // [R04]
            lims_pkg::LIMS_MODE_LINKIDLE:      cond = isUp && !busy; // [R05]
            lims_pkg::LIMS_MODE_LINK10:        cond = is10; // [R06]
            lims_pkg::LIMS_MODE_LINK100:       cond = is100; // [R07]
            lims_pkg::LIMS_MODE_LINK1000:      cond = is1000; // [R08]
         endcase
      end

      // Blink gating only masks a true condition, so a false one stays off.
      assign gated     = cond && (!cfg.blink || blinkPhase); // [R10] [R14]
      // Invert clear means active-low: lit drives the pin low.
      assign ledNxt[i] = cfg.invert ? gated : !gated; // [R11] [R13]
   end

   // ----------------------------------------------------------------------
   // Output register
   // ----------------------------------------------------------------------

   // Registered pins avoid glitches from the mode decode.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ledOut <= lims_pkg::LIMS_LED_IDLE;
      end else begin
         ledOut <= ledNxt;
      end
   end

endmodule
`default_nettype wire

// [verification/lims_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// Ties each indicator pin to the mode table, settled past the input sync.
module lims_chk (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        linkUp,
   input wire logic [1:0]  linkSpeed,
   input wire logic        txActive,
   input wire logic        rxActive,
   input wire logic        ctlLoad,
   input wire logic [15:0] indicatorControlIn,
   input wire logic [15:0] indicatorControl,
   input wire logic [2:0]  ledOut
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Condition per mode code; speed code 3 matches no speed.
   wire logic [15:0] ic   = indicatorControl;
   wire logic        act  = txActive | rxActive;
   wire logic [3:0]  sp   = 4'h1 << linkSpeed;
   wire logic [7:0]  cond = {8{linkUp}} & {sp[2], sp[1], sp[0], !act, act,
                            1'b1, sp[1] | sp[2], sp[0] | sp[2]};
   wire logic [2:0]  want = {cond[ic[12:10]], cond[ic[7:5]], cond[ic[2:0]]};
   wire logic [2:0]  inv  = {ic[13], ic[8], ic[3]};
   wire logic [2:0]  blk  = {ic[14], ic[9], ic[4]};

   // Five calm cycles cover the two-flop sync plus the pin register.
   sequence quiet;
      (!ctlLoad && $stable(linkUp) && $stable(linkSpeed)
       && $stable(txActive) && $stable(rxActive))[*5];
   endsequence

   out0_steady_a:
      assert property (quiet |-> blk[0] || ledOut[0] == ~(want[0] ^ inv[0]))
      else $error("pin 0 level wrong");
   out1_steady_a:
      assert property (quiet |-> blk[1] || ledOut[1] == ~(want[1] ^ inv[1]))
      else $error("pin 1 level wrong");
   out2_steady_a:
      assert property (quiet |-> blk[2] || ledOut[2] == ~(want[2] ^ inv[2]))
      else $error("pin 2 level wrong");
   dark_blink_a:
      assert property (quiet |-> ((ledOut ~^ inv) & blk & ~want) == 3'h0)
      else $error("blinking pin lit with false condition");
   steady_hold_a:
      assert property (quiet ##0 (blk == 3'h0) |-> $stable(ledOut))
      else $error("steady pin moved");
   ctl_load_a:
      assert property (ctlLoad |=>
         indicatorControl == $past(indicatorControlIn))
      else $error("control word not loaded");
   ctl_hold_a:
      assert property (!ctlLoad |=> $stable(indicatorControl))
      else $error("control word changed unasked");
   reset_val_a:
      assert property ($fell(reset) |->
         indicatorControl == lims_pkg::LIMS_CTL_RESET && ledOut == 3'h7)
      else $error("reset state wrong");
endmodule

bind led_indication_mode_selector lims_chk i_chk (.clk_sys, .reset, .linkUp,
   .linkSpeed, .txActive, .rxActive, .ctlLoad, .indicatorControlIn,
   .indicatorControl, .ledOut);

`default_nettype wire

// [verification/lims_led_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Lamps tied from pin to supply, so a low pin glows.
module lims_led_model (
   input  wire logic [2:0] pin,
   output var  logic [2:0] glow
);
   assign glow = ~pin;
endmodule

`default_nettype wire

// [verification/led_indication_mode_selector_test.sv]
`timescale 1ns/1ps
`default_nettype none

module led_indication_mode_selector_test;
   typedef struct packed {
      logic [15:0] c;
      logic        u;
      logic [1:0]  s;
      logic        t;
      logic        r;
      logic [2:0]  e;
   } lims_row_t;
   logic        clk_sys, reset, linkUp, txActive, rxActive, ctlLoad;
   logic [1:0]  linkSpeed;
   logic [15:0] indicatorControlIn, indicatorControl;
   logic [2:0]  ledOut, glow;
   int          fail_count = 0, checks = 0, cyc = 0, halfLen;
   // Control word, link, speed, tx, rx, expected pins (low is lit where invert is clear).
   lims_row_t rows [12] = '{
      '{16'h0820, 1'h1, 2'h0, 1'h0, 1'h0, 3'h2},
      '{16'h0820, 1'h1, 2'h1, 1'h0, 1'h0, 3'h1},
      '{16'h0820, 1'h1, 2'h2, 1'h0, 1'h0, 3'h0},
      '{16'h0820, 1'h1, 2'h3, 1'h0, 1'h0, 3'h3},
      '{16'h0820, 1'h0, 2'h2, 1'h0, 1'h0, 3'h7},
      '{16'h1483, 1'h1, 2'h0, 1'h1, 1'h0, 3'h2},
      '{16'h1483, 1'h1, 2'h1, 1'h0, 1'h0, 3'h5},
      '{16'h1483, 1'h1, 2'h0, 1'h0, 1'h1, 3'h2},
      '{16'h1483, 1'h0, 2'h0, 1'h1, 1'h0, 3'h7},
      '{16'h28F6, 1'h1, 2'h1, 1'h0, 1'h0, 3'h6},
      '{16'h28F6, 1'h1, 2'h2, 1'h0, 1'h0, 3'h5},
      '{16'h28F6, 1'h0, 2'h2, 1'h0, 1'h0, 3'h3}};

   led_indication_mode_selector i_dut (.clk_sys, .reset, .linkUp, .linkSpeed,
      .txActive, .rxActive, .ctlLoad, .indicatorControlIn, .indicatorControl,
      .ledOut);
   lims_led_model i_lamps (.pin(ledOut), .glow);
   // One clock stands for one millisecond of blink time, so both rates
   // show in a short run; the table finishes before the first flip.
   defparam i_dut.u_timer.SLOW_CYCLES = lims_pkg::LIMS_SLOW_HALF_MS;
   defparam i_dut.u_timer.FAST_CYCLES = lims_pkg::LIMS_FAST_HALF_MS;

   // Clock at 25 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // A run past 2000 cycles means something hung.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic cmp(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Drives one row, pulsing the load when asked, then lets it settle.
   task automatic apply(input lims_row_t r, input logic ld);
      @(posedge clk_sys);
      ctlLoad <= ld;
      indicatorControlIn <= r.c;
      {linkUp, linkSpeed, txActive, rxActive} <= {r.u, r.s, r.t, r.r};
      @(posedge clk_sys);
      ctlLoad <= 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      cmp("pins", {13'h0, r.e}, {13'h0, ledOut});
   endtask

   // Counts edges until pin 0 next changes; bounded so a stuck pin ends.
   task automatic gap(output int len);
      logic was;
      was = ledOut[0];
      len = 0;
      do begin
         @(posedge clk_sys);
         #1;
         len++;
      end while (ledOut[0] === was && len < 1000);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      {reset, linkUp, linkSpeed, txActive, rxActive, ctlLoad} = 7'h40;
      indicatorControlIn = 16'h0000;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      cmp("ctl", lims_pkg::LIMS_CTL_RESET, indicatorControl);
      cmp("pins", 16'h0007, {13'h0, ledOut});
      apply('{16'h0, 1'h1, 2'h2, 1'h0, 1'h0, 3'h4}, 1'b0);
      $display("test reset defaults done");
      foreach (rows[i]) apply(rows[i], 1'b1);
      cmp("glow", 16'h0004, {13'h0, glow});
      $display("test mode table done");
      @(posedge clk_sys);
      ctlLoad <= 1'b1;
      indicatorControlIn <= 16'h0820;
      @(posedge clk_sys);
      indicatorControlIn <= 16'h1483;
      apply(rows[5], 1'b0);
      cmp("ctl", 16'h1483, indicatorControl);
      $display("test back to back load done");
      // Pin 0 blinks on any link; the first changes may follow the load
      // or a restart, so only the last of three gaps is measured.
      @(posedge clk_sys);
      ctlLoad <= 1'b1;
      indicatorControlIn <= 16'h0012;
      @(posedge clk_sys);
      ctlLoad <= 1'b0;
      repeat (3) gap(halfLen);
      cmp("slow", 16'(lims_pkg::LIMS_SLOW_HALF_MS), 16'(halfLen));
      @(posedge clk_sys);
      ctlLoad <= 1'b1;
      indicatorControlIn <= 16'h8012;
      @(posedge clk_sys);
      ctlLoad <= 1'b0;
      repeat (3) gap(halfLen);
      cmp("fast", 16'(lims_pkg::LIMS_FAST_HALF_MS), 16'(halfLen));
      $display("test blink rates done");
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      cmp("ctl", lims_pkg::LIMS_CTL_RESET, indicatorControl);
      cmp("pins", 16'h0007, {13'h0, ledOut});
      $display("test mid-run reset done");
      final_report();
   end
endmodule

`default_nettype wire
